// >>> rtl/omcc_pkg.sv
// What this block does
// - In fast running mode the CPU clock comes from the fast oscillator divided by 1 to 64, set by the divider select and high/low select.
// - In slow running mode the CPU clock comes from the sub clock and the fast clock is switched off.
// - A halt with idle enable clear enters sleep mode and stops the CPU.
// - In sleep mode the sub clock keeps running so the watchdog keeps counting.
// - A halt with idle enable set and keep-on clear enters deep idle mode.
// - Deep idle stops the system oscillator and the CPU clock while watchdog and timer keep running.
// - A halt with idle enable and keep-on both set enters clocked idle mode.
// - Clocked idle gates the CPU clock but keeps the selected system oscillator running for peripherals.
// - Clocked idle keeps the watchdog clock enabled from the sub clock.
// - The 8-bit mode register holds divider select in bits 7..5, oscillator ready flags in bits 3..2, idle enable in bit 1 and high/low select in bit 0, resetting to 8'h03.
package omcc_pkg;
    // Register map
    localparam logic [1:0] OMCC_ADDR_MODE = 2'h0;
    localparam logic [1:0] OMCC_ADDR_CTRL = 2'h1;
    localparam logic [7:0] OMCC_MODE_RESET = 8'h03;
    localparam logic [7:0] OMCC_CTRL_RESET = 8'h00;
    // Mode and control register fields
    localparam int OMCC_DIV_HI = 7;
    localparam int OMCC_DIV_LO = 5;
    localparam int OMCC_LOW_RDY_BIT = 3;
    localparam int OMCC_HIGH_RDY_BIT = 2;
    localparam int OMCC_IDLE_EN_BIT = 1;
    localparam int OMCC_HL_SEL_BIT = 0;
    localparam int OMCC_KEEP_ON_BIT = 0;
    // Divider encodings
    localparam logic [2:0] OMCC_DIV_FIRST_FAST = 3'h2;
    localparam logic [5:0] OMCC_DIV_MASK_64 = 6'h3F;

    // Operating modes, Gray coded in the order listed
    typedef enum logic [2:0] {
        OMCC_RUN_FAST = 3'b000,
        OMCC_RUN_SLOW = 3'b001,
        OMCC_SLEEP = 3'b011,
        OMCC_DEEP_IDLE = 3'b010,
        OMCC_CLOCKED_IDLE = 3'b110
    } omcc_mode_t;
endpackage

// >>> rtl/omcc_clock_control.sv
`timescale 1ns/1ps
`default_nettype none
module omcc_clock_control
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Register port
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Oscillator ticks and status
    input wire logic fast_tick,
    input wire logic sub_tick,
    input wire logic high_osc_stable,
    input wire logic low_osc_stable,
    // CPU events
    input wire logic halt_instruction,
    input wire logic wake_event,
    // Clock enables and status
    output logic cpu_clk_en,
    output logic sys_clk_en,
    output logic fast_osc_on,
    output logic sub_clk_en,
    output logic wdt_clk_en,
    output logic timer_clk_en,
    output var omcc_pkg::omcc_mode_t mode
);
    import omcc_pkg::*;

    logic [2:0] div_sel_q;
    logic idle_en_q;
    logic hl_sel_q;
    logic keep_on_q;
    logic low_rdy_q;
    logic high_rdy_q;
    logic [5:0] div_cnt_q;
    omcc_mode_t mode_q;
    omcc_mode_t mode_d;
    logic [7:0] rdata_q;
    logic cpu_en_q;
    logic sys_en_q;
    logic fast_on_q;
    logic sub_en_q;
    logic wdt_en_q;
    logic timer_en_q;
    logic fast_sel;
    logic [5:0] div_mask;
    logic div_tick;
    logic sys_tick;
    logic running;
    logic running_d;
    logic [7:0] mode_reg;

    // Writable fields of the mode register
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            div_sel_q <= OMCC_MODE_RESET[OMCC_DIV_HI:OMCC_DIV_LO];
            idle_en_q <= OMCC_MODE_RESET[OMCC_IDLE_EN_BIT];
            hl_sel_q <= OMCC_MODE_RESET[OMCC_HL_SEL_BIT];
        end
        else if (reg_wr && reg_addr == OMCC_ADDR_MODE)
        begin
            div_sel_q <= reg_wdata[OMCC_DIV_HI:OMCC_DIV_LO];
            idle_en_q <= reg_wdata[OMCC_IDLE_EN_BIT];
            hl_sel_q <= reg_wdata[OMCC_HL_SEL_BIT];
        end
    end

    // Keep-on bit in its own control register
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            keep_on_q <= OMCC_CTRL_RESET[OMCC_KEEP_ON_BIT];
        else if (reg_wr && reg_addr == OMCC_ADDR_CTRL)
            keep_on_q <= reg_wdata[OMCC_KEEP_ON_BIT];
    end

    // Ready flags are read-only, sampled from the oscillators
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            low_rdy_q <= OMCC_MODE_RESET[OMCC_LOW_RDY_BIT];
            high_rdy_q <= OMCC_MODE_RESET[OMCC_HIGH_RDY_BIT];
        end
        else
        begin
            low_rdy_q <= low_osc_stable;
            high_rdy_q <= high_osc_stable && fast_on_q;
        end
    end

    // Register image; bit 4 unused reads zero
    always_comb
    begin
        mode_reg = 8'h00;
        mode_reg[OMCC_DIV_HI:OMCC_DIV_LO] = div_sel_q;
        mode_reg[OMCC_LOW_RDY_BIT] = low_rdy_q;
        mode_reg[OMCC_HIGH_RDY_BIT] = high_rdy_q;
        mode_reg[OMCC_IDLE_EN_BIT] = idle_en_q;
        mode_reg[OMCC_HL_SEL_BIT] = hl_sel_q;
    end

    // Read data one cycle after the strobe, zero otherwise
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            rdata_q <= 8'h00;
        else if (reg_rd && reg_addr == OMCC_ADDR_MODE)
            rdata_q <= mode_reg;
        else if (reg_rd && reg_addr == OMCC_ADDR_CTRL)
            rdata_q <= {7'h00, keep_on_q};
        else
            rdata_q <= 8'h00;
    end

    // Clock source selection
    assign fast_sel = hl_sel_q || (div_sel_q >= OMCC_DIV_FIRST_FAST);
    assign div_mask = OMCC_DIV_MASK_64 >> (div_sel_q - OMCC_DIV_FIRST_FAST);
    assign div_tick = fast_tick && ((div_cnt_q & div_mask) == div_mask);
    assign sys_tick = hl_sel_q ? fast_tick : (fast_sel ? div_tick : sub_tick);
    assign running = (mode_q == OMCC_RUN_FAST) || (mode_q == OMCC_RUN_SLOW);
    // Next-cycle view, so the system enable drops in the same edge as the mode
    assign running_d = (mode_d == OMCC_RUN_FAST) || (mode_d == OMCC_RUN_SLOW);

    // Prescaler counts fast ticks; frozen while the fast oscillator is off
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            div_cnt_q <= 6'h00;
        else if (fast_tick && fast_on_q)
            div_cnt_q <= div_cnt_q + 6'h01;
    end

    // Mode sequencing: halt picks a low-power mode, wake returns to running
    always_comb
    begin
        mode_d = mode_q;
        if (running)
        begin
            mode_d = fast_sel ? OMCC_RUN_FAST : OMCC_RUN_SLOW;
            if (halt_instruction)
            begin
                if (!idle_en_q)
                    mode_d = OMCC_SLEEP;
                else if (!keep_on_q)
                    mode_d = OMCC_DEEP_IDLE;
                else
                    mode_d = OMCC_CLOCKED_IDLE;
            end
        end
        else if (wake_event)
        begin
            mode_d = fast_sel ? OMCC_RUN_FAST : OMCC_RUN_SLOW;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
            mode_q <= OMCC_RUN_FAST;
        else
            mode_q <= mode_d;
    end

    // Oscillator enable; fast off unless selected and needed
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            fast_on_q <= 1'b1;
        else
        begin
            case (mode_d)
                OMCC_RUN_FAST: fast_on_q <= 1'b1;
                OMCC_RUN_SLOW: fast_on_q <= 1'b0;
                OMCC_CLOCKED_IDLE: fast_on_q <= fast_sel;
                OMCC_SLEEP: fast_on_q <= 1'b0;
                OMCC_DEEP_IDLE: fast_on_q <= 1'b0;
                default: fast_on_q <= 1'b0;
            endcase
        end
    end

    // Clock enables, registered so outputs are glitch free
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            cpu_en_q <= 1'b0;
            sys_en_q <= 1'b0;
            sub_en_q <= 1'b0;
            wdt_en_q <= 1'b0;
            timer_en_q <= 1'b0;
        end
        else
        begin
            cpu_en_q <= running && sys_tick;
            sys_en_q <= (running_d || mode_d == OMCC_CLOCKED_IDLE) && sys_tick;
            sub_en_q <= sub_tick;
            wdt_en_q <= sub_tick;
            timer_en_q <= (mode_q == OMCC_DEEP_IDLE || mode_q == OMCC_SLEEP) ? sub_tick :
                ((running || mode_q == OMCC_CLOCKED_IDLE) && sys_tick);
        end
    end

    // Outputs straight from flops
    assign reg_rdata = rdata_q;
    assign cpu_clk_en = cpu_en_q;
    assign sys_clk_en = sys_en_q;
    assign fast_osc_on = fast_on_q;
    assign sub_clk_en = sub_en_q;
    assign wdt_clk_en = wdt_en_q;
    assign timer_clk_en = timer_en_q;
    assign mode = mode_q;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    // Halt with idle clear lands in sleep
    property p_sleep_entry;
        running && halt_instruction && !idle_en_q |=> mode_q == OMCC_SLEEP;
    endproperty
    a_sleep_entry: assert property (p_sleep_entry) else $error("halt did not enter sleep");

    property p_deep_entry;
        running && halt_instruction && idle_en_q && !keep_on_q |=> mode_q == OMCC_DEEP_IDLE;
    endproperty
    a_deep_entry: assert property (p_deep_entry) else $error("halt did not enter deep idle");

    property p_clocked_entry;
        running && halt_instruction && idle_en_q && keep_on_q |=> mode_q == OMCC_CLOCKED_IDLE;
    endproperty
    a_clocked_entry: assert property (p_clocked_entry) else $error("halt did not enter clocked idle");

    property p_cpu_stopped;
        !running |=> !cpu_en_q;
    endproperty
    a_cpu_stopped: assert property (p_cpu_stopped) else $error("cpu clock ran while halted");

    property p_slow_fast_off;
        mode_q == OMCC_RUN_SLOW |-> !fast_on_q;
    endproperty
    a_slow_fast_off: assert property (p_slow_fast_off) else $error("fast clock on in slow mode");

    property p_deep_osc_off;
        mode_q == OMCC_DEEP_IDLE |-> !fast_on_q && !sys_en_q;
    endproperty
    a_deep_osc_off: assert property (p_deep_osc_off) else $error("oscillator active in deep idle");

    property p_wdt_sub;
        sub_tick |=> wdt_en_q && sub_en_q;
    endproperty
    a_wdt_sub: assert property (p_wdt_sub) else $error("watchdog clock missed a sub tick");

    property p_clocked_sys;
        mode_q == OMCC_CLOCKED_IDLE && sys_tick |=> sys_en_q && !cpu_en_q;
    endproperty
    a_clocked_sys: assert property (p_clocked_sys) else $error("clocked idle lost system clock");

    property p_undivided;
        running && hl_sel_q && fast_tick |=> cpu_en_q;
    endproperty
    a_undivided: assert property (p_undivided) else $error("undivided fast clock missed");

    property p_readback;
        reg_rd && reg_addr == OMCC_ADDR_MODE |=> rdata_q[4] == 1'b0 && rdata_q[1:0] == $past({idle_en_q, hl_sel_q});
    endproperty
    a_readback: assert property (p_readback) else $error("mode register readback wrong");

    property p_div64;
        running && !$past(hl_sel_q) && $past(div_sel_q) == OMCC_DIV_FIRST_FAST && cpu_en_q
            |-> $past(div_cnt_q) == OMCC_DIV_MASK_64;
    endproperty
    a_div64: assert property (p_div64) else $error("divide by 64 wrong");

    // Sleep keeps the fast oscillator off
    property p_sleep_fast_off;
        mode_q == OMCC_SLEEP |-> !fast_on_q;
    endproperty
    a_sleep_fast_off: assert property (p_sleep_fast_off) else $error("fast clock on in sleep");

    // Sleep still passes every sub tick to the watchdog
    property p_sleep_sub;
        mode_q == OMCC_SLEEP && sub_tick |=> sub_en_q && wdt_en_q;
    endproperty
    a_sleep_sub: assert property (p_sleep_sub) else $error("sub clock lost in sleep");

    // Timer keeps counting sub ticks in deep idle
    property p_deep_timer;
        mode_q == OMCC_DEEP_IDLE && sub_tick |=> timer_en_q;
    endproperty
    a_deep_timer: assert property (p_deep_timer) else $error("timer stopped in deep idle");

    // Selected fast oscillator stays up while idling clocked
    property p_clocked_osc;
        mode_q == OMCC_CLOCKED_IDLE && mode_d == OMCC_CLOCKED_IDLE && fast_sel |=> fast_on_q;
    endproperty
    a_clocked_osc: assert property (p_clocked_osc) else $error("oscillator stopped in clocked idle");

    // Watchdog clock from the sub clock in clocked idle
    property p_clocked_wdt;
        mode_q == OMCC_CLOCKED_IDLE && sub_tick |=> wdt_en_q;
    endproperty
    a_clocked_wdt: assert property (p_clocked_wdt) else $error("watchdog clock off in clocked idle");

    // Slow running clocks the CPU from sub ticks
    property p_slow_sub_cpu;
        mode_q == OMCC_RUN_SLOW && !fast_sel && sub_tick |=> cpu_en_q;
    endproperty
    a_slow_sub_cpu: assert property (p_slow_sub_cpu) else $error("slow cpu missed a sub tick");

    // Fast running always has its oscillator on
    property p_fast_on_run;
        mode_q == OMCC_RUN_FAST |-> fast_on_q;
    endproperty
    a_fast_on_run: assert property (p_fast_on_run) else $error("fast oscillator off while running fast");

    // A halt while already halted changes nothing
    property p_halt_ignored;
        !running && halt_instruction && !wake_event |=> mode_q == $past(mode_q);
    endproperty
    a_halt_ignored: assert property (p_halt_ignored) else $error("halt taken while halted");

    // Ready flags ignore software writes
    property p_ready_ro;
        reg_wr && reg_addr == OMCC_ADDR_MODE |=> low_rdy_q == $past(low_osc_stable);
    endproperty
    a_ready_ro: assert property (p_ready_ro) else $error("ready flag written by software");

    // Keep-on bit reads back from the control register
    property p_ctrl_read;
        reg_rd && reg_addr == OMCC_ADDR_CTRL |=> rdata_q == {7'h00, $past(keep_on_q)};
    endproperty
    a_ctrl_read: assert property (p_ctrl_read) else $error("control register readback wrong");

    c_sleep: cover property (mode_q == OMCC_SLEEP ##[1:20] running);
    c_deep: cover property (mode_q == OMCC_DEEP_IDLE && wdt_en_q);
    c_clocked: cover property (mode_q == OMCC_CLOCKED_IDLE && sys_en_q);
    c_slow: cover property (mode_q == OMCC_RUN_SLOW && cpu_en_q);
endmodule
`default_nettype wire

// >>> dv/omcc_clock_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
module omcc_clock_control_bench;
    import omcc_pkg::*;
    // Stimulus and observed signals
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [1:0] reg_addr = 2'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic fast_tick = 1'b0;
    logic sub_tick = 1'b0;
    logic high_osc_stable = 1'b0;
    logic low_osc_stable = 1'b0;
    logic halt_instruction = 1'b0;
    logic wake_event = 1'b0;
    logic cpu_clk_en, sys_clk_en, fast_osc_on, sub_clk_en, wdt_clk_en, timer_clk_en;
    omcc_mode_t mode;
    int fails = 0;
    int n_compared = 0;
    int n_cpu, n_sys, n_wdt, n_tmr, n_sub;
    logic [2:0] sub_cnt_q = 3'h0;
    logic [7:0] rd_v;

    omcc_clock_control omcc_clock_control_i (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .fast_tick(fast_tick), .sub_tick(sub_tick), .high_osc_stable(high_osc_stable),
        .low_osc_stable(low_osc_stable), .halt_instruction(halt_instruction), .wake_event(wake_event),
        .cpu_clk_en(cpu_clk_en), .sys_clk_en(sys_clk_en), .fast_osc_on(fast_osc_on),
        .sub_clk_en(sub_clk_en), .wdt_clk_en(wdt_clk_en), .timer_clk_en(timer_clk_en), .mode(mode));

    // 50 MHz clock
    initial
    begin
        forever #10 clk = ~clk;
    end

    // Fast tick every cycle, sub tick every eighth, so a 256-cycle window is exact
    always_ff @(posedge clk)
    begin
        fast_tick <= 1'b1;
        sub_cnt_q <= sub_cnt_q + 3'h1;
        sub_tick <= (sub_cnt_q == 3'h7);
    end

    task automatic chk(input string name, input logic [8:0] seen, input logic [8:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fails++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic test_done();
        if (fails == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic pulse_halt(input logic w);
        @(posedge clk);
        if (w)
            wake_event <= 1'b1;
        else
            halt_instruction <= 1'b1;
        @(posedge clk);
        halt_instruction <= 1'b0;
        wake_event <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    // Count enable pulses over a fixed window of 256 cycles
    task automatic measure();
        n_cpu = 0;
        n_sys = 0;
        n_wdt = 0;
        n_tmr = 0;
        n_sub = 0;
        repeat (256)
        begin
            @(posedge clk);
            #1;
            n_cpu += (cpu_clk_en === 1'b1);
            n_sys += (sys_clk_en === 1'b1);
            n_wdt += (wdt_clk_en === 1'b1);
            n_tmr += (timer_clk_en === 1'b1);
            n_sub += (sub_clk_en === 1'b1);
        end
    endtask

    // Reset image, read-only bits and unmapped places
    task automatic t_regs();
        rd(OMCC_ADDR_MODE, rd_v); chk("mode reg reset", rd_v, 9'h003);
        rd(OMCC_ADDR_CTRL, rd_v); chk("ctrl reg reset", rd_v, 9'h000);
        wr(2'h2, 8'hFF);
        rd(2'h2, rd_v); chk("unmapped read", rd_v, 9'h000);
        wr(OMCC_ADDR_MODE, 8'hFF);
        rd(OMCC_ADDR_MODE, rd_v); chk("read-only bits", rd_v, 9'h0E3);
        high_osc_stable <= 1'b1;
        low_osc_stable <= 1'b1;
        repeat (2) @(posedge clk);
        rd(OMCC_ADDR_MODE, rd_v); chk("ready flags", rd_v, 9'h0EF);
    endtask

    // Divider codes 2 to 7, then undivided fast clock
    task automatic t_fast();
        for (int c = 2; c < 8; c++)
        begin
            wr(OMCC_ADDR_MODE, {c[2:0], 5'h00});
            repeat (4) @(posedge clk);
            measure();
            chk("divided cpu pulses", n_cpu[8:0], 9'(256 >> (8 - c)));
            chk("mode fast", 9'(mode), 9'(OMCC_RUN_FAST));
        end
        wr(OMCC_ADDR_MODE, 8'h01);
        repeat (4) @(posedge clk);
        measure();
        chk("undivided cpu pulses", n_cpu[8:0], 9'd256);
    endtask

    // Sub clock running mode switches the fast oscillator off
    task automatic t_slow();
        wr(OMCC_ADDR_MODE, 8'h00);
        repeat (4) @(posedge clk);
        chk("mode slow", 9'(mode), 9'(OMCC_RUN_SLOW));
        chk("fast osc off", 9'(fast_osc_on), 9'h000);
        measure();
        chk("slow cpu pulses", n_cpu[8:0], 9'd32);
    endtask

    // Halt into each low-power mode from fast undivided running
    task automatic t_halt(input logic ie, input logic ko, input omcc_mode_t m);
        wr(OMCC_ADDR_MODE, {6'h00, ie, 1'b1});
        wr(OMCC_ADDR_CTRL, {7'h00, ko});
        pulse_halt(1'b0);
        chk("halt mode", 9'(mode), 9'(m));
        measure();
        chk("cpu stopped", n_cpu[8:0], 9'h000);
        chk("sub clock runs", n_sub[8:0], 9'd32);
        chk("watchdog runs", n_wdt[8:0], 9'd32);
        if (m == OMCC_DEEP_IDLE)
        begin
            chk("deep osc off", 9'(fast_osc_on), 9'h000);
            chk("deep sys off", n_sys[8:0], 9'h000);
            chk("deep timer runs", 9'(n_tmr != 0), 9'h001);
        end
        if (m == OMCC_CLOCKED_IDLE)
        begin
            chk("idle osc on", 9'(fast_osc_on), 9'h001);
            chk("idle sys runs", 9'(n_sys != 0), 9'h001);
        end
        pulse_halt(1'b0);
        chk("halt ignored", 9'(mode), 9'(m));
        pulse_halt(1'b1);
        chk("woken mode", 9'(mode), 9'(OMCC_RUN_FAST));
    endtask

    // Run limit
    initial
    begin
        repeat (100000) @(posedge clk);
        fails++;
        test_done();
    end

    initial
    begin
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        t_regs();
        t_fast();
        t_slow();
        t_halt(1'b0, 1'b0, OMCC_SLEEP);
        t_halt(1'b1, 1'b0, OMCC_DEEP_IDLE);
        t_halt(1'b1, 1'b1, OMCC_CLOCKED_IDLE);
        test_done();
    end
endmodule
`default_nettype wire
